// ### inc/pvc_pkg.sv
package pvc_pkg;
    // register indices on the management bus
    localparam logic [4:0] IDX_MODE_CTRL = 5'h11;
    localparam logic [4:0] IDX_SPECIAL   = 5'h12;
    localparam logic [4:0] IDX_EXT_MODE  = 5'h13;
    localparam logic [4:0] IDX_ADR_PORT  = 5'h14;
    localparam logic [4:0] IDX_RD_DATA   = 5'h15;
    localparam logic [4:0] IDX_CLK_STAT  = 5'h1b;

    // field positions
    localparam int SM_EARLY_RXDV = 15;
    localparam int SM_HD_LB_DIS  = 14;
    localparam int SM_CRC_SRC    = 7;
    localparam int SM_MCLK_SEL   = 6;
    localparam int EM_MODE_LSB   = 11;
    localparam int EM_FIFO_LSB   = 9;
    localparam int EM_MDIX01     = 2;
    localparam int EM_MDIX23     = 1;
    localparam int EM_CPD        = 0;
    localparam int AP_READ       = 15;
    localparam int CS_TXC_DLY    = 9;
    localparam int CS_RXC_DLY    = 8;
    localparam int CS_RX_POL     = 4;
    localparam int MC_XOVER_DIS  = 5;

    // writable bits and bits kept through a soft reset
    localparam logic [15:0] SM_WMASK = 16'hc09f;
    localparam logic [15:0] SM_KEEP  = 16'h401f;
    localparam logic [15:0] EM_WMASK = 16'hfe07;
    localparam logic [15:0] EM_KEEP  = 16'hf800;
    localparam logic [15:0] AP_WMASK = 16'h7fff;
    localparam logic [15:0] CS_WMASK = 16'h0300;
    localparam logic [15:0] CS_KEEP  = 16'h0300;
    localparam logic [15:0] MC_WMASK = 16'h0020;

    // values after reset
    localparam logic [15:0] SM_RST_BASE   = 16'h0000;
    localparam logic [15:0] EM_RST_BASE   = 16'h0000;
    localparam logic [15:0] CS_RST_BASE   = 16'h0000;
    localparam logic [15:0] AP_RST        = 16'h0000;
    localparam logic [15:0] MC_RST        = 16'h0000;
    localparam logic [15:0] RD_DATA_RST   = 16'h0000;
    localparam logic [2:0]  ADDR_STRAP_HI = 3'h0;
    localparam logic [2:0]  MODE_STRAP_HI = 3'h0;

    // advanced register window
    localparam int         ADV_DEPTH = 13;
    localparam logic [6:0] ADV_LAST  = 7'h0c;

    // management frame counts, in management clock bits
    localparam logic [5:0] PRE_LEN   = 6'h20;
    localparam logic [5:0] HDR_LAST  = 6'h0c;
    localparam logic [5:0] TA_LAST   = 6'h01;
    localparam logic [5:0] DATA_LAST = 6'h0f;
    localparam logic [5:0] DATA_BITS = 6'h10;
    localparam logic [1:0] OP_RD     = 2'h2;
    localparam logic [1:0] OP_WR     = 2'h1;

    typedef enum logic [2:0] {
        ST_PRE   = 3'b000,
        ST_HDR   = 3'b001,
        ST_TA_RD = 3'b010,
        ST_TA_WR = 3'b011,
        ST_RD    = 3'b100,
        ST_WR    = 3'b101
    } pvc_mdio_state_t;

    typedef struct packed {
        logic [3:0] config_pins;
        logic       clock_delay_strap;
    } pvc_strap_t;

    typedef struct packed {
        logic mac_clock_freq_select;
        logic rx_polarity_reversed;
        logic link_10hd;
        logic adv_10hd;
        logic adv_100hd;
    } pvc_status_t;

    typedef struct packed {
        logic       early_rxdv_en;
        logic       hd_loopback_active;
        logic       crc_src_tx;
        logic [1:0] tx_fifo_depth;
        logic       auto_xover_dis;
        logic       mdi_x_ch01;
        logic       mdi_x_ch23;
        logic       pd_10hd_allowed;
        logic       pd_100hd_allowed;
        logic       tx_clk_delay_en;
        logic       rx_clk_delay_en;
        logic [4:0] operating_mode_field;
        logic [4:0] station_address;
    } pvc_cfg_t;

    function automatic logic [15:0] sm_default(input pvc_strap_t s);
        sm_default = SM_RST_BASE | {11'h000, ADDR_STRAP_HI, s.config_pins[1:0]};
    endfunction

    function automatic logic [15:0] em_default(input pvc_strap_t s);
        em_default = EM_RST_BASE | {MODE_STRAP_HI, s.config_pins[3:2], 11'h000};
    endfunction

    function automatic logic [15:0] cs_default(input pvc_strap_t s);
        cs_default = CS_RST_BASE | {6'h00, {2{s.clock_delay_strap}}, 8'h00};
    endfunction
endpackage

// ### rtl/pvc_adv_mem.sv
module pvc_adv_mem (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        wr_en_i,
    input  wire logic [3:0]  wr_addr_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        rd_en_i,
    input  wire logic [6:0]  rd_addr_i,
    output logic      [15:0] rd_data_o
);
    import pvc_pkg::*;

    logic [15:0] mem_reg [ADV_DEPTH];

    // contents carry no reset: the datapath refreshes them
    always_ff @(posedge clk_i) begin
        if (wr_en_i && ({3'h0, wr_addr_i} <= ADV_LAST)) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rd_data_o <= RD_DATA_RST;
        end else if (rd_en_i) begin
            // addresses past the window read as zero
            rd_data_o <= (rd_addr_i <= ADV_LAST) ? mem_reg[rd_addr_i[3:0]] : 16'h0000;
        end
    end
endmodule

// ### rtl/pvc_vendor_regs.sv
// What this block does
// - bit 15 enables early receive-valid in 10BASE-T
// - bit 14 set disables 10BASE-T half-duplex loopback
// - bit 7 picks CRC counter source, rx/tx
// - read-only bit 6 shows MAC clock rate
// - station address matches frames, seeds scrambler, strapped
// - operating mode defaults from upper config straps
// - transmit FIFO depth field, four to seven bytes
// - manual MDI/MDI-X per channel pair when crossover off
// - bit 0 chooses plain or conditional parallel detect
// - read bit copies advanced register, then self-clears
// - seven-bit advanced address, range 0-12, resets zero
// - advanced read data port, read-only, resets zero
// - bits 9 and 8 enable transmit/receive clock delay
// - delay enables default from the clock delay strap
// - read-only bit 4 shows receive polarity reversed
// - crossover disable bit, default automatic crossover
module pvc_vendor_regs (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 soft_reset_i,
    input  wire pvc_pkg::pvc_strap_t  strap_i,
    input  wire pvc_pkg::pvc_status_t status_i,
    input  wire logic                 mdc_i,
    input  wire logic                 mdio_i,
    output logic                      mdio_o,
    output logic                      mdio_oe_o,
    input  wire logic                 adv_wr_en_i,
    input  wire logic [3:0]           adv_wr_addr_i,
    input  wire logic [15:0]          adv_wr_data_i,
    output pvc_pkg::pvc_cfg_t         cfg_o
);
    import pvc_pkg::*;

    pvc_mdio_state_t state_reg;
    pvc_strap_t      strap_reg;
    logic            mdc_reg;
    logic            mdc_rise;
    logic [5:0]      cnt_reg;
    logic [15:0]     sh_reg;
    logic [4:0]      idx_reg;
    logic            wr_reg;
    logic [4:0]      wr_idx_reg;
    logic [15:0]     wr_data_reg;
    logic [15:0]     spec_reg;
    logic [15:0]     ext_reg;
    logic [15:0]     aport_reg;
    logic [15:0]     cs_reg;
    logic [15:0]     mc_reg;
    logic [15:0]     rd_data_reg;
    logic            adv_rd_en;
    logic            adv_rd_valid_reg;
    logic [15:0]     adv_q;
    logic [4:0]      hdr_phy;
    logic [1:0]      hdr_op;
    logic [4:0]      hdr_reg;

    // readback image; read-only status bits are live, reserved bits read zero
    function automatic logic [15:0] reg_read(input logic [4:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            IDX_SPECIAL: begin
                v = spec_reg & SM_WMASK;
                v[SM_MCLK_SEL] = status_i.mac_clock_freq_select;
            end
            IDX_EXT_MODE: begin
                v = ext_reg & EM_WMASK;
            end
            IDX_ADR_PORT: begin
                v = aport_reg & AP_WMASK;
            end
            IDX_RD_DATA: begin
                v = rd_data_reg;
            end
            IDX_CLK_STAT: begin
                v = cs_reg & CS_WMASK;
                v[CS_RX_POL] = status_i.rx_polarity_reversed;
            end
            IDX_MODE_CTRL: begin
                v = mc_reg & MC_WMASK;
            end
            default: begin
                v = 16'h0000;
            end
        endcase
        return v;
    endfunction

    // management clock is sampled as plain data, so mdc must be well below clk_i
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            // held high so a clock parked high at release is not taken for a rise
            mdc_reg <= 1'b1;
        end else begin
            mdc_reg <= mdc_i;
        end
    end

    assign mdc_rise = mdc_i & ~mdc_reg;
    assign hdr_op   = sh_reg[10:9];
    assign hdr_phy  = sh_reg[8:4];
    assign hdr_reg  = {sh_reg[3:0], mdio_i};

    // serial management frame engine
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg   <= ST_PRE;
            cnt_reg     <= 6'h00;
            sh_reg      <= 16'h0000;
            idx_reg     <= 5'h00;
            mdio_o      <= 1'b0;
            mdio_oe_o   <= 1'b0;
            wr_reg      <= 1'b0;
            wr_idx_reg  <= 5'h00;
            wr_data_reg <= 16'h0000;
        end else begin
            wr_reg <= 1'b0;
            if (mdc_rise) begin
                case (state_reg)
                    ST_PRE: begin
                        if (mdio_i) begin
                            cnt_reg <= (cnt_reg == PRE_LEN) ? cnt_reg : cnt_reg + 6'h01;
                        end else if (cnt_reg == PRE_LEN) begin
                            state_reg <= ST_HDR;
                            cnt_reg   <= 6'h00;
                        end else begin
                            cnt_reg <= 6'h00;
                        end
                    end
                    ST_HDR: begin
                        sh_reg  <= {sh_reg[14:0], mdio_i};
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg == HDR_LAST) begin
                            cnt_reg <= 6'h00;
                            idx_reg <= hdr_reg;
                            // only frames to our own station address are answered
                            if (sh_reg[11] && hdr_phy == spec_reg[4:0] && hdr_op == OP_RD) begin
                                state_reg <= ST_TA_RD;
                                sh_reg    <= reg_read(hdr_reg);
                            end else if (sh_reg[11] && hdr_phy == spec_reg[4:0] && hdr_op == OP_WR) begin
                                state_reg <= ST_TA_WR;
                            end else begin
                                state_reg <= ST_PRE;
                            end
                        end
                    end
                    ST_TA_RD: begin
                        mdio_oe_o <= 1'b1;
                        mdio_o    <= 1'b0;
                        state_reg <= ST_RD;
                    end
                    ST_RD: begin
                        cnt_reg <= cnt_reg + 6'h01;
                        mdio_o  <= sh_reg[15];
                        sh_reg  <= {sh_reg[14:0], 1'b0};
                        if (cnt_reg == DATA_BITS) begin
                            mdio_oe_o <= 1'b0;
                            mdio_o    <= 1'b0;
                            cnt_reg   <= 6'h00;
                            state_reg <= ST_PRE;
                        end
                    end
                    ST_TA_WR: begin
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg == TA_LAST) begin
                            cnt_reg   <= 6'h00;
                            state_reg <= ST_WR;
                        end
                    end
                    ST_WR: begin
                        sh_reg  <= {sh_reg[14:0], mdio_i};
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg == DATA_LAST) begin
                            wr_reg      <= 1'b1;
                            wr_idx_reg  <= idx_reg;
                            wr_data_reg <= {sh_reg[14:0], mdio_i};
                            cnt_reg     <= 6'h00;
                            state_reg   <= ST_PRE;
                        end
                    end
                    default: begin
                        state_reg <= ST_PRE;
                        cnt_reg   <= 6'h00;
                        mdio_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // straps are caught while reset is held, and reused on a soft reset
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            strap_reg <= strap_i;
        end
    end

    // configuration registers; soft reset wins over a write in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            spec_reg <= sm_default(strap_i);
            ext_reg  <= em_default(strap_i);
            cs_reg   <= cs_default(strap_i);
            mc_reg   <= MC_RST;
        end else if (soft_reset_i) begin
            spec_reg <= (spec_reg & SM_KEEP) | (sm_default(strap_reg) & ~SM_KEEP);
            ext_reg  <= (ext_reg & EM_KEEP) | (em_default(strap_reg) & ~EM_KEEP);
            cs_reg   <= (cs_reg & CS_KEEP) | (cs_default(strap_reg) & ~CS_KEEP);
            mc_reg   <= MC_RST;
        end else if (wr_reg) begin
            case (wr_idx_reg)
                IDX_SPECIAL:   spec_reg <= wr_data_reg & SM_WMASK;
                IDX_EXT_MODE:  ext_reg <= wr_data_reg & EM_WMASK;
                IDX_CLK_STAT:  cs_reg <= wr_data_reg & CS_WMASK;
                IDX_MODE_CTRL: mc_reg <= wr_data_reg & MC_WMASK;
                default: begin
                end
            endcase
        end
    end

    // advanced address port; the read bit is never stored, so it reads back cleared
    assign adv_rd_en = wr_reg && wr_idx_reg == IDX_ADR_PORT && wr_data_reg[AP_READ];

    always_ff @(posedge clk_i) begin
        if (!rst_b_i || soft_reset_i) begin
            aport_reg <= AP_RST;
        end else if (wr_reg && wr_idx_reg == IDX_ADR_PORT) begin
            aport_reg <= wr_data_reg & AP_WMASK;
        end
    end

    pvc_adv_mem u_adv_mem (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (adv_wr_en_i),
        .wr_addr_i (adv_wr_addr_i),
        .wr_data_i (adv_wr_data_i),
        .rd_en_i   (adv_rd_en),
        .rd_addr_i (wr_data_reg[6:0]),
        .rd_data_o (adv_q)
    );

    // latched copy: later datapath updates do not disturb what software reads
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || soft_reset_i) begin
            adv_rd_valid_reg <= 1'b0;
            rd_data_reg      <= RD_DATA_RST;
        end else begin
            adv_rd_valid_reg <= adv_rd_en;
            if (adv_rd_valid_reg) begin
                rd_data_reg <= adv_q;
            end
        end
    end

    // controls to the datapath, registered
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o.early_rxdv_en        <= spec_reg[SM_EARLY_RXDV];
            cfg_o.hd_loopback_active   <= status_i.link_10hd & ~spec_reg[SM_HD_LB_DIS];
            cfg_o.crc_src_tx           <= spec_reg[SM_CRC_SRC];
            cfg_o.tx_fifo_depth        <= ext_reg[EM_FIFO_LSB+:2];
            cfg_o.auto_xover_dis       <= mc_reg[MC_XOVER_DIS];
            cfg_o.mdi_x_ch01           <= mc_reg[MC_XOVER_DIS] & ext_reg[EM_MDIX01];
            cfg_o.mdi_x_ch23           <= mc_reg[MC_XOVER_DIS] & ext_reg[EM_MDIX23];
            cfg_o.pd_10hd_allowed      <= ~ext_reg[EM_CPD] | status_i.adv_10hd;
            cfg_o.pd_100hd_allowed     <= ~ext_reg[EM_CPD] | status_i.adv_100hd;
            cfg_o.tx_clk_delay_en      <= cs_reg[CS_TXC_DLY];
            cfg_o.rx_clk_delay_en      <= cs_reg[CS_RXC_DLY];
            cfg_o.operating_mode_field <= ext_reg[EM_MODE_LSB+:5];
            cfg_o.station_address      <= spec_reg[4:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i || soft_reset_i);

    a_early_rxdv_follow: assert property (
        wr_reg && wr_idx_reg == IDX_SPECIAL |-> ##2 cfg_o.early_rxdv_en == $past(wr_data_reg[15], 2))
        else $error("early rx valid enable does not follow write");

    a_loopback_hd_only: assert property (
        !status_i.link_10hd || spec_reg[SM_HD_LB_DIS] |=> !cfg_o.hd_loopback_active)
        else $error("loopback active outside 10 half duplex or when disabled");

    a_crc_src_follow: assert property (
        wr_reg && wr_idx_reg == IDX_SPECIAL |-> ##2 cfg_o.crc_src_tx == $past(wr_data_reg[7], 2))
        else $error("crc source select does not follow write");

    a_ro_bits_ignored: assert property (
        wr_reg && wr_idx_reg == IDX_SPECIAL |=> (spec_reg & ~SM_WMASK) == 16'h0000)
        else $error("read-only bits of special modes took a write");

    a_addr_from_strap: assert property (
        $rose(rst_b_i) |-> spec_reg[4:0] == {ADDR_STRAP_HI, $past(strap_i.config_pins[1:0])})
        else $error("station address default not from straps");

    a_mode_from_strap: assert property (
        $rose(rst_b_i) |-> ext_reg[15:11] == {MODE_STRAP_HI, $past(strap_i.config_pins[3:2])})
        else $error("operating mode default not from straps");

    a_fifo_depth_follow: assert property (
        wr_reg && wr_idx_reg == IDX_EXT_MODE |-> ##2 cfg_o.tx_fifo_depth == $past(wr_data_reg[10:9], 2))
        else $error("tx fifo depth does not follow write");

    a_mdix_manual_only: assert property (
        !mc_reg[MC_XOVER_DIS] |=> !cfg_o.mdi_x_ch01 && !cfg_o.mdi_x_ch23)
        else $error("manual crossover applied while auto crossover on");

    a_plain_par_detect: assert property (
        !ext_reg[EM_CPD] |=> cfg_o.pd_10hd_allowed && cfg_o.pd_100hd_allowed)
        else $error("parallel detect restricted while conditional mode off");

    a_adv_read_latch: assert property (
        adv_rd_en |-> ##2 rd_data_reg == $past(adv_q))
        else $error("advanced register not latched into read data port");

    a_addr_field_wr: assert property (
        wr_reg && wr_idx_reg == IDX_ADR_PORT |=> aport_reg[6:0] == $past(wr_data_reg[6:0]) && !aport_reg[15])
        else $error("advanced address field or read bit wrong after write");

    a_delay_strap_low: assert property (
        $rose(rst_b_i) && !$past(strap_i.clock_delay_strap) |-> cs_reg[9:8] == 2'b00)
        else $error("clock delays enabled with delay strap low");

    a_read_turnaround: assert property (
        state_reg == ST_TA_RD && mdc_rise |=> mdio_oe_o && !mdio_o)
        else $error("no driven zero in read turnaround");

    c_mdio_read: cover property (state_reg == ST_RD && cnt_reg == DATA_BITS && mdc_rise);
    c_mdio_write: cover property (wr_reg && wr_idx_reg == IDX_EXT_MODE);
    c_adv_read: cover property (adv_rd_en ##2 rd_data_reg != 16'h0000);
endmodule

// ### tb/pvc_smi_master.sv
module pvc_smi_master (
    input  wire logic clk_i,
    input  wire logic mdio_i,
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      mdio_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        mdc_o     = 1'b0;
        mdio_o    = 1'b1;
        mdio_oe_o = 1'b0;
    end

    // data changes only while mdc is low, so it is stable at the rise
    task automatic bit_cyc(input logic d, input logic oe, output logic q);
        @(negedge clk_i);
        mdc_o     = 1'b0;
        mdio_o    = d;
        mdio_oe_o = oe;
        repeat (5) @(negedge clk_i);
        q     = mdio_i;
        mdc_o = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask

    task automatic xfer(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        q;
        hdr = {2'b01, ~wr, wr, phy, ra};
        repeat (32) bit_cyc(1'b1, 1'b1, q);
        for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, q);
        // released on reads so the device can take the line
        bit_cyc(1'b1, wr, q);
        bit_cyc(1'b0, wr, q);
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(wd[i], wr, q);
            rd[i] = q;
        end
        mdio_oe_o = 1'b0;
    endtask
endmodule

// ### tb/tb_phy_vendor_config_regs.sv
module tb_phy_vendor_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import pvc_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_b_i, soft_reset_i, mdc, mdio_w, d_mdio, d_oe, m_mdio, m_oe;
    logic        adv_wr_en_i;
    logic [3:0]  adv_wr_addr_i;
    logic [15:0] adv_wr_data_i;
    pvc_strap_t  strap_i;
    pvc_status_t status_i;
    pvc_cfg_t    cfg_o;
    logic [15:0] r17, r18, r19, r20, r21, r27, rd, wd;
    logic [15:0] mem [13];
    logic [4:0]  ra;
    logic [4:0]  sl [7] = '{IDX_MODE_CTRL, IDX_SPECIAL, IDX_EXT_MODE, IDX_ADR_PORT, IDX_RD_DATA, IDX_CLK_STAT, 5'h16};
    logic [4:0]  wl [4] = '{IDX_MODE_CTRL, IDX_SPECIAL, IDX_EXT_MODE, IDX_CLK_STAT};
    logic [6:0]  al [5] = '{7'h00, 7'h07, 7'h0c, 7'h0d, 7'h7f};
    int          errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          seed = 56;

    always #5 clk_i = ~clk_i;
    // pull-up holds the line high when nobody drives it
    assign mdio_w = d_oe ? d_mdio : (m_oe ? m_mdio : 1'b1);

    pvc_vendor_regs uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .soft_reset_i(soft_reset_i), .strap_i(strap_i),
        .status_i(status_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(d_mdio), .mdio_oe_o(d_oe),
        .adv_wr_en_i(adv_wr_en_i), .adv_wr_addr_i(adv_wr_addr_i), .adv_wr_data_i(adv_wr_data_i), .cfg_o(cfg_o));
    pvc_smi_master u_smi (.clk_i(clk_i), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(m_mdio), .mdio_oe_o(m_oe));

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    function logic [15:0] exp_rd(input logic [4:0] a);
        case (a)
            IDX_MODE_CTRL: exp_rd = r17;
            IDX_SPECIAL:   exp_rd = r18 | {9'h000, status_i.mac_clock_freq_select, 6'h00};
            IDX_EXT_MODE:  exp_rd = r19;
            IDX_ADR_PORT:  exp_rd = r20;
            IDX_RD_DATA:   exp_rd = r21;
            IDX_CLK_STAT:  exp_rd = r27 | {11'h000, status_i.rx_polarity_reversed, 4'h0};
            default:       exp_rd = 16'h0000;
        endcase
    endfunction

    function pvc_cfg_t exp_cfg();
        pvc_cfg_t c;
        c.early_rxdv_en        = r18[15];
        c.hd_loopback_active   = status_i.link_10hd & ~r18[14];
        c.crc_src_tx           = r18[7];
        c.tx_fifo_depth        = r19[10:9];
        c.auto_xover_dis       = r17[5];
        c.mdi_x_ch01           = r17[5] & r19[2];
        c.mdi_x_ch23           = r17[5] & r19[1];
        c.pd_10hd_allowed      = ~r19[0] | status_i.adv_10hd;
        c.pd_100hd_allowed     = ~r19[0] | status_i.adv_100hd;
        c.tx_clk_delay_en      = r27[9];
        c.rx_clk_delay_en      = r27[8];
        c.operating_mode_field = r19[15:11];
        c.station_address      = r18[4:0];
        return c;
    endfunction

    task wr(input logic [4:0] a, input logic [15:0] d);
        u_smi.xfer(1'b1, r18[4:0], a, d, rd);
        case (a)
            IDX_MODE_CTRL: r17 = d & MC_WMASK;
            IDX_SPECIAL:   r18 = d & SM_WMASK;
            IDX_EXT_MODE:  r19 = d & EM_WMASK;
            IDX_CLK_STAT:  r27 = d & CS_WMASK;
            IDX_ADR_PORT: begin
                r20 = d & AP_WMASK;
                if (d[15]) r21 = (d[6:0] <= 7'h0c) ? mem[d[6:0]] : 16'h0000;
            end
            default: ;
        endcase
    endtask

    task rd_chk(input logic [4:0] a);
        u_smi.xfer(1'b0, r18[4:0], a, 16'h0000, rd);
        chk("read data", {16'h0000, rd}, {16'h0000, exp_rd(a)});
        chk("cfg", 32'(cfg_o), 32'(exp_cfg()));
    endtask

    // both delay strap levels are seen over the two hard resets
    task hard_reset(input logic dly);
        @(negedge clk_i);
        rst_b_i = 1'b0;
        strap_i = {4'($random(seed)), dly};
        repeat (6) @(negedge clk_i);
        rst_b_i = 1'b1;
        r17 = 16'h0000;
        r18 = {14'h0000, strap_i.config_pins[1:0]};
        r19 = {3'h0, strap_i.config_pins[3:2], 11'h000};
        r20 = 16'h0000;
        r21 = 16'h0000;
        r27 = {6'h00, {2{strap_i.clock_delay_strap}}, 8'h00};
        foreach (sl[i]) rd_chk(sl[i]);
    endtask

    initial begin
        rst_b_i = 1'b0;
        soft_reset_i = 1'b0;
        adv_wr_en_i = 1'b0;
        adv_wr_addr_i = 4'h0;
        adv_wr_data_i = 16'h0000;
        status_i = 5'h00;
        strap_i = 5'h00;
        for (int k = 0; k < 2; k++) begin
            hard_reset(k[0]);
            for (int i = 0; i < 8; i++) begin
                @(negedge clk_i);
                status_i = 5'($random(seed));
                wd = 16'($random(seed));
                ra = wl[i % 4];
                // mode field kept by read-modify-write
                if (ra == IDX_EXT_MODE) wd = (wd & 16'h07ff) | (r19 & 16'hf800);
                wr(ra, wd);
                rd_chk(ra);
            end
        end
        // the write port takes one word each cycle; index 13 is outside the window
        for (int a = 0; a < 14; a++) begin
            @(negedge clk_i);
            adv_wr_en_i = 1'b1;
            adv_wr_addr_i = 4'(a);
            adv_wr_data_i = 16'($random(seed));
            if (a < 13) mem[a] = adv_wr_data_i;
        end
        @(negedge clk_i);
        adv_wr_en_i = 1'b0;
        foreach (al[i]) begin
            wr(IDX_ADR_PORT, {1'b1, 8'h03, al[i]});
            rd_chk(IDX_RD_DATA);
            rd_chk(IDX_ADR_PORT);
        end
        // frames for another station address must not touch anything
        u_smi.xfer(1'b1, r18[4:0] ^ 5'h01, IDX_EXT_MODE, r19 ^ 16'h0600, rd);
        rd_chk(IDX_EXT_MODE);
        u_smi.xfer(1'b0, r18[4:0] ^ 5'h01, IDX_SPECIAL, 16'h0000, rd);
        chk("foreign read", {16'h0000, rd}, 32'h0000ffff);
        @(negedge clk_i);
        soft_reset_i = 1'b1;
        @(negedge clk_i);
        soft_reset_i = 1'b0;
        r17 = 16'h0000;
        r18 = r18 & SM_KEEP;
        r19 = r19 & EM_KEEP;
        r20 = 16'h0000;
        r21 = 16'h0000;
        r27 = r27 & CS_KEEP;
        foreach (sl[i]) rd_chk(sl[i]);
        results();
    end

    // bounded run: about 45k cycles are expected
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            results();
        end
    end
endmodule
